// File: logic/rcrf_pkg.sv
package rcrf_pkg;
    // geometry
    localparam int          CHAN_N        = 4;            // receive channels
    localparam int          CHAR_BITS     = 10;           // bits per character
    localparam logic [3:0]  LAST_BIT      = 4'h9;         // bit count at natural wrap
    localparam logic [3:0]  HALF_CHAR     = 4'h5;         // clock high for counts below this
    // three-level select codes
    localparam logic [1:0]  SEL_LOW       = 2'h0;
    localparam logic [1:0]  SEL_MID       = 2'h1;
    localparam logic [1:0]  SEL_HIGH      = 2'h2;
    // framing patterns, earliest bit at msb
    localparam logic [7:0]  COMMA_POS     = 8'h3E;        // 00111110xx
    localparam logic [7:0]  COMMA_NEG     = 8'hC1;        // 11000001xx
    localparam logic [9:0]  K28_NEG       = 10'h0FA;      // 0011111010
    localparam logic [9:0]  K28_POS       = 10'h305;      // 1100000101
    // framer figures
    localparam logic [3:0]  STRETCH_MAX   = 4'h2;         // bit periods per char cycle
    localparam int          STD_SPAN_BITS = 50;           // two matches within this span
    localparam logic [5:0]  STD_GAP_MAX   = 6'(STD_SPAN_BITS - CHAR_BITS - 1);
    localparam logic [5:0]  ALT_GAP       = 6'(CHAR_BITS - 1); // back-to-back chars
    localparam logic [5:0]  SINCE_MAX     = 6'h3F;        // saturation
    localparam logic [2:0]  STD_MATCHES   = 3'h2;
    localparam logic [2:0]  ALT_MATCHES   = 3'h4;
    // link fault figures
    localparam logic [6:0]  NOTRANS_BITS  = 7'h3C;        // 60 bits without transition
    localparam logic [6:0]  IDLE_MAX      = 7'h7F;
    localparam logic [1:0]  TRANS_CHARS   = 2'h3;         // adjacent chars to release
    // range monitor
    localparam int          RANGE_PERIODS = 16000;        // training periods per sample
    localparam int          PPM_TOL       = 1500;
    // timing
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          REENABLE_MS   = 2;
    localparam int          REENABLE_CYC  = REENABLE_MS * 1000000 / CLK_PERIOD_NS;
    typedef enum logic {RCRF_LF_FAULT, RCRF_LF_OK} rcrf_lf_e;
endpackage

// File: logic/rcrf_ptrn_match.sv
`timescale 1ns/1ps
module rcrf_ptrn_match
(
    input  wire logic [rcrf_pkg::CHAR_BITS-1:0] i_window,      // last ten bits, newest at lsb
    input  wire logic [1:0]                     i_pattern_sel, // framing_pattern_sel
    output logic                                o_match        // selected pattern seen
);
    import rcrf_pkg::*;

    logic [7:0] head;  // eight leading bits of the window

    // comma uses eight bits: seven plus the inverted seventh, fewer false frames
    always_comb
    begin
        head = i_window[CHAR_BITS-1 -: 8];
        unique case (i_pattern_sel)
            SEL_MID:  o_match = (head == COMMA_POS) || (head == COMMA_NEG);
            SEL_HIGH: o_match = (i_window == K28_NEG) || (i_window == K28_POS);
            default:  o_match = 1'b0;  // low is a test setting, never frames
        endcase
    end
endmodule

// File: logic/rcrf_top.sv
`timescale 1ns/1ps
module rcrf_top
#(
    parameter int CHAN_N       = rcrf_pkg::CHAN_N,        // channel count
    parameter int REENABLE_CYC = rcrf_pkg::REENABLE_CYC,  // blanking after re-enable
    parameter int RANGE_PER    = rcrf_pkg::RANGE_PERIODS  // training periods per sample
)
(
    input  wire logic                           i_clk,                          // bit clock
    input  wire logic                           i_reset_n,                      // sync reset
    input  wire logic                           i_training_clock,               // sampled training clock
    input  wire logic                           i_training_clock_half_rate_sel, // training at bit/20
    input  wire logic [1:0]                     i_speed_range_sel,              // low/mid/high
    input  wire logic [1:0]                     i_framing_pattern_sel,          // pattern choice
    input  wire logic [1:0]                     i_framer_mode_sel,              // framer variant
    input  wire logic                           i_framer_enable,                // all framers on
    input  wire logic                           i_output_clock_half_rate,       // char clock / 2
    input  wire logic [CHAN_N-1:0]              i_channel_enable,               // per channel on
    input  wire logic [CHAN_N-1:0]              i_serial_input_sel,             // alternate input
    input  wire logic [CHAN_N-1:0]              i_serial_in_a,                  // primary bit
    input  wire logic [CHAN_N-1:0]              i_serial_in_b,                  // alternate bit
    output logic [CHAN_N-1:0]                   o_recovered_char_clock,         // per channel
    output logic [CHAN_N-1:0]                   o_char_strobe,                  // char ready pulse
    output logic [rcrf_pkg::CHAR_BITS-1:0]      o_char [CHAN_N],                // framed chars
    output logic [CHAN_N-1:0]                   o_data_valid,                   // not blanked
    output logic [CHAN_N-1:0]                   o_link_fault_n,                 // low on fault
    output logic [CHAN_N-1:0]                   o_tracking_training,            // loop on reference
    output logic                                o_ref_char_tick,                // multiplier tick
    output logic                                o_config_reserved               // illegal speed combo
);
    import rcrf_pkg::*;

    localparam int          BLANK_W  = $clog2(REENABLE_CYC + 1);
    localparam int          RNG_W    = $clog2(RANGE_PER + 1);
    localparam logic [15:0] EXP_FULL = 16'(RANGE_PER);            // chars per sample
    localparam logic [15:0] EXP_HALF = 16'(2 * RANGE_PER);
    localparam logic [15:0] TOL      = 16'(RANGE_PER * PPM_TOL / 1000000);

    logic             ll_mode;          // low latency framer
    logic             alt_mode;         // four-in-a-row framer
    assign ll_mode  = (i_framer_mode_sel == SEL_LOW);
    assign alt_mode = (i_framer_mode_sel == SEL_HIGH);

    // training clock multiplier and range sampler state
    logic             trg_d_reg, trg_d_next;            // previous training level
    logic [15:0]      trg_per_reg, trg_per_next;        // clocks per training period
    logic [15:0]      trg_cnt_reg, trg_cnt_next;        // clocks since last rise
    logic [RNG_W-1:0] rng_reg, rng_next;                // training periods counted
    logic             tick_reg, tick_next;              // registered tick
    logic             rsv_reg, rsv_next;                // reserved config flag
    logic             trg_rise;                         // training rising edge
    logic             ref_tick;                         // character-rate tick
    logic             sample;                           // range sample instant

    // one tick per rise; half-rate training adds a midpoint tick
    always_comb
    begin
        trg_rise     = i_training_clock && !trg_d_reg;
        ref_tick     = trg_rise || (i_training_clock_half_rate_sel
                       && (trg_cnt_reg == (trg_per_reg >> 1)));
        sample       = trg_rise && (rng_reg == RNG_W'(RANGE_PER - 1));
        trg_d_next   = i_training_clock;
        trg_cnt_next = trg_rise ? 16'h0000 : trg_cnt_reg + 16'h0001;
        trg_per_next = trg_rise ? trg_cnt_reg + 16'h0001 : trg_per_reg;
        rng_next     = rng_reg;
        if (trg_rise)
        begin
            rng_next = sample ? '0 : rng_reg + RNG_W'(1);
        end
        tick_next    = ref_tick;
        rsv_next     = (i_speed_range_sel == SEL_LOW) && i_training_clock_half_rate_sel;
    end

    // registers only
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            trg_d_reg   <= 1'b0;
            trg_per_reg <= '0;
            trg_cnt_reg <= '0;
            rng_reg     <= '0;
            tick_reg    <= 1'b0;
            rsv_reg     <= 1'b0;
        end
        else
        begin
            trg_d_reg   <= trg_d_next;
            trg_per_reg <= trg_per_next;
            trg_cnt_reg <= trg_cnt_next;
            rng_reg     <= rng_next;
            tick_reg    <= tick_next;
            rsv_reg     <= rsv_next;
        end
    end
    assign o_ref_char_tick   = tick_reg;
    assign o_config_reserved = rsv_reg;

    a_reserved_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_speed_range_sel == SEL_LOW) && i_training_clock_half_rate_sel |=> o_config_reserved)
        else $error("reserved speed setting not flagged");

    genvar g;
    generate
        for (g = 0; g < CHAN_N; g++)
        begin : g_ch
            logic [19:0]        sh_reg, sh_next;        // received bits, newest at lsb
            logic [3:0]         cnt_reg, cnt_next;      // bit position in char clock
            logic [3:0]         pend_reg, pend_next;    // stretch bits still owed
            logic [3:0]         off_reg, off_next;      // data offset, multi-byte
            logic [3:0]         cand_reg, cand_next;    // boundary being counted
            logic [2:0]         mcnt_reg, mcnt_next;    // matches on candidate
            logic [5:0]         since_reg, since_next;  // bits since last match
            logic [9:0]         char_reg, char_next;    // framed character
            logic               stb_reg, stb_next;      // char strobe
            logic               rclk_reg, rclk_next;    // recovered char clock
            logic [6:0]         idle_reg, idle_next;    // bits without transition
            logic               ctr_reg, ctr_next;      // transition in this char
            logic [1:0]         tch_reg, tch_next;      // adjacent chars with transition
            rcrf_lf_e           lf_reg, lf_next;        // link fault state
            logic [15:0]        nch_reg, nch_next;      // chars in range window
            logic               trk_reg, trk_next;      // tracking training clock
            logic               en_reg, en_next;        // channel enable, delayed
            logic [BLANK_W-1:0] blk_reg, blk_next;      // re-enable blanking count
            logic               val_reg, val_next;      // data valid
            logic               lfn_reg, lfn_next;      // link fault output
            logic               bit_in;                 // selected serial bit
            logic               match;                  // pattern ends at this bit
            logic               wrap;                   // char clock wraps now
            logic               trans;                  // bit differs from previous
            logic [3:0]         stretch;                // stretch this cycle
            logic [3:0]         cand_new;               // boundary of this match
            logic [15:0]        expct;                  // expected chars per window
            logic [15:0]        diff;                   // rate error in chars

            // new input invalidates nothing here; caller waits for relock and reframe
            assign bit_in = i_serial_input_sel[g] ? i_serial_in_b[g] : i_serial_in_a[g];

            rcrf_ptrn_match u_match
            (
                .i_window      ({sh_reg[8:0], bit_in}),
                .i_pattern_sel (i_framing_pattern_sel),
                .o_match       (match)
            );

            // framer, char clock, link fault and range state
            always_comb
            begin
                sh_next   = {sh_reg[18:0], bit_in};
                stretch   = (pend_reg > STRETCH_MAX) ? STRETCH_MAX : pend_reg;
                wrap      = cnt_reg >= (LAST_BIT + (ll_mode ? stretch : 4'h0));
                cand_new  = LAST_BIT - cnt_reg;
                trans     = bit_in ^ sh_reg[0];
                cnt_next  = wrap ? 4'h0 : cnt_reg + 4'h1;
                pend_next = ll_mode ? ((wrap) ? pend_reg - stretch : pend_reg) : 4'h0;
                off_next  = off_reg;
                cand_next = cand_reg;
                mcnt_next = mcnt_reg;
                since_next = (since_reg == SINCE_MAX) ? since_reg : since_reg + 6'h01;
                // disabled framers start no new boundary; a low latency stretch already owed still runs out
                if (i_framer_enable && match && !trk_reg)
                begin
                    since_next = 6'h00;
                    if (ll_mode)
                    begin
                        // first match starts the stretch; clock moves, data offset 0
                        if (pend_reg == 4'h0 && cnt_reg != LAST_BIT)
                        begin
                            pend_next = cnt_reg + 4'h1;
                        end
                    end
                    else if (cand_new == cand_reg && mcnt_reg != 3'h0
                             && (alt_mode ? (since_reg == ALT_GAP)
                                          : (since_reg <= STD_GAP_MAX)))
                    begin
                        mcnt_next = mcnt_reg + 3'h1;
                        if (mcnt_next == (alt_mode ? ALT_MATCHES : STD_MATCHES))
                        begin
                            off_next  = cand_reg;
                            mcnt_next = 3'h0;
                        end
                    end
                    else
                    begin
                        cand_next = cand_new;
                        mcnt_next = 3'h1;
                    end
                end
                // off-range loop follows the reference tick instead of the data
                if (trk_reg && ref_tick)
                begin
                    cnt_next  = 4'h0;
                    pend_next = 4'h0;
                end
                char_next = wrap ? sh_next[(ll_mode ? 4'h0 : off_reg) +: CHAR_BITS] : char_reg;
                stb_next  = wrap;
                rclk_next = i_output_clock_half_rate ? (rclk_reg ^ wrap) : (cnt_next < HALF_CHAR);
                // transition density watch
                idle_next = trans ? 7'h00 : ((idle_reg == IDLE_MAX) ? idle_reg : idle_reg + 7'h01);
                ctr_next  = wrap ? 1'b0 : (ctr_reg | trans);
                tch_next  = tch_reg;
                if (wrap)
                begin
                    tch_next = (ctr_reg | trans) ? ((tch_reg == TRANS_CHARS) ? tch_reg : tch_reg + 2'h1)
                                                 : 2'h0;
                end
                unique case (lf_reg)
                    RCRF_LF_FAULT: lf_next = (tch_reg == TRANS_CHARS) ? RCRF_LF_OK : RCRF_LF_FAULT;
                    RCRF_LF_OK:    lf_next = (idle_reg > NOTRANS_BITS) ? RCRF_LF_FAULT : RCRF_LF_OK;
                endcase
                if (!i_channel_enable[g])
                begin
                    lf_next = RCRF_LF_FAULT;
                end
                // range monitor compares char count with the reference
                expct    = i_training_clock_half_rate_sel ? EXP_HALF : EXP_FULL;
                diff     = (nch_reg > expct) ? nch_reg - expct : expct - nch_reg;
                nch_next = sample ? 16'h0000 : (wrap ? nch_reg + 16'h0001 : nch_reg);
                trk_next = sample ? (diff > TOL) : trk_reg;
                // blanking after re-enable; a short trade against a lock detector
                en_next  = i_channel_enable[g];
                blk_next = (i_channel_enable[g] && !en_reg) ? BLANK_W'(REENABLE_CYC)
                         : ((blk_reg != '0) ? blk_reg - BLANK_W'(1) : blk_reg);
                val_next = i_channel_enable[g] && (blk_next == '0) && (lf_next == RCRF_LF_OK);
                lfn_next = (lf_next == RCRF_LF_OK) && i_channel_enable[g] && !trk_next;
            end

            // registers only
            always_ff @(posedge i_clk)
            begin
                if (!i_reset_n)
                begin
                    sh_reg <= '0; cnt_reg <= '0; pend_reg <= '0; off_reg <= '0;
                    cand_reg <= '0; mcnt_reg <= '0; since_reg <= SINCE_MAX; char_reg <= '0;
                    stb_reg <= 1'b0; rclk_reg <= 1'b0; idle_reg <= '0; ctr_reg <= 1'b0;
                    tch_reg <= '0; lf_reg <= RCRF_LF_FAULT; nch_reg <= '0; trk_reg <= 1'b0;
                    en_reg <= 1'b0; blk_reg <= '0; val_reg <= 1'b0; lfn_reg <= 1'b0;
                end
                else
                begin
                    sh_reg <= sh_next; cnt_reg <= cnt_next; pend_reg <= pend_next; off_reg <= off_next;
                    cand_reg <= cand_next; mcnt_reg <= mcnt_next; since_reg <= since_next;
                    char_reg <= char_next; stb_reg <= stb_next; rclk_reg <= rclk_next;
                    idle_reg <= idle_next; ctr_reg <= ctr_next; tch_reg <= tch_next; lf_reg <= lf_next;
                    nch_reg <= nch_next; trk_reg <= trk_next; en_reg <= en_next; blk_reg <= blk_next;
                    val_reg <= val_next; lfn_reg <= lfn_next;
                end
            end

            assign o_recovered_char_clock[g] = rclk_reg;
            assign o_char_strobe[g]          = stb_reg;
            assign o_char[g]                 = char_reg;
            assign o_data_valid[g]           = val_reg;
            assign o_link_fault_n[g]         = lfn_reg;
            assign o_tracking_training[g]    = trk_reg;

            a_stretch_limit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                wrap |-> cnt_reg <= LAST_BIT + STRETCH_MAX)
                else $error("char clock stretched too far");
            a_disabled_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                !i_framer_enable && pend_reg == 4'h0 |=> $stable(off_reg) && pend_reg == 4'h0)
                else $error("boundary moved with framer disabled");
            a_ll_latency: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                ll_mode && i_framer_enable && match && !trk_reg && pend_reg == 4'h0
                && cnt_reg != LAST_BIT |=> ##[0:90] pend_reg == 4'h0)
                else $error("low latency alignment too slow");
            a_alt_commit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                off_reg != $past(off_reg) && $past(alt_mode) |-> $past(mcnt_reg) == 3'h3
                && $past(since_reg) == ALT_GAP)
                else $error("alternate framer moved early");
            a_std_commit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                off_reg != $past(off_reg) && !$past(alt_mode) |-> $past(mcnt_reg) == 3'h1
                && $past(since_reg) <= STD_GAP_MAX)
                else $error("standard framer moved early");
            a_restart_count: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                i_framer_enable && match && !trk_reg && !ll_mode && cand_new != cand_reg
                |=> mcnt_reg == 3'h1 && cand_reg == $past(cand_new))
                else $error("count not restarted on new boundary");
            a_fault_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                idle_reg > NOTRANS_BITS |=> ##1 !o_link_fault_n[g])
                else $error("idle line not flagged");
            a_range_track: assert property (@(posedge i_clk) disable iff (!i_reset_n)
                sample && diff > TOL |=> o_tracking_training[g] && !o_link_fault_n[g])
                else $error("out of range not tracked");
        end
    endgenerate
endmodule

// File: testbench/rcrf_remote_tx.sv
`timescale 1ns/1ps
module rcrf_remote_tx
(
    input  wire logic       i_clk,     // bit clock
    input  wire logic       i_reset_n, // sync reset
    input  wire logic [9:0] i_char,    // next character to send
    input  wire logic       i_quiet,   // hold a flat line
    output logic            o_bit      // serial bit, earliest first
);
    logic [9:0] shift_reg; // bits still to leave
    logic [3:0] cnt_reg;   // bit slot in current char
    // whole chars every ten bits, msb first
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            shift_reg <= 10'h000;
            cnt_reg   <= 4'h0;
        end
        else
        begin
            cnt_reg   <= (cnt_reg == 4'h9) ? 4'h0 : cnt_reg + 4'h1;
            shift_reg <= (cnt_reg == 4'h9) ? i_char : {shift_reg[8:0], 1'b0};
        end
    end
    // flat line only when a scenario starves transitions
    assign o_bit = i_quiet ? 1'b0 : shift_reg[9];
endmodule

// File: testbench/rcrf_top_test.sv
`timescale 1ns/1ps
module rcrf_top_test;
    import rcrf_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, trg = 1'b0, half = 1'b0, fen = 1'b0, quiet = 1'b0, tx_bit, tick, resv;
    logic [1:0] spd = 2'h2, pat = 2'h2, mode = 2'h0;
    logic [3:0] sel = 4'h0, cen = 4'hF, rclk, strb, dv, lf, trk;
    logic [2:0] dly = 3'h0;     // primary input lags one bit, alternate three: both off the char clock
    logic       orate = 1'b0;   // recovered clock at half rate
    logic [3:0] tcnt = 4'h0;    // training clock phase
    logic [9:0] chr [4];
    int         num_errors = 0, checked = 0;
    always #50 clk = ~clk;
    // training clock at bit rate over ten, same source as the far end
    always @(posedge clk)
    begin
        tcnt <= (tcnt == 4'h9) ? 4'h0 : tcnt + 4'h1;
        trg  <= (tcnt < 4'h5);
        dly  <= {dly[1:0], tx_bit};
    end
    rcrf_remote_tx tx (.i_clk(clk), .i_reset_n(rst_n), .i_char(K28_NEG), .i_quiet(quiet), .o_bit(tx_bit));
    rcrf_top #(.REENABLE_CYC(20)) dut (.i_clk(clk), .i_reset_n(rst_n), .i_training_clock(trg),
        .i_training_clock_half_rate_sel(half), .i_speed_range_sel(spd), .i_framing_pattern_sel(pat),
        .i_framer_mode_sel(mode), .i_framer_enable(fen), .i_output_clock_half_rate(orate),
        .i_channel_enable(cen), .i_serial_input_sel(sel), .i_serial_in_a({4{dly[0]}}),
        .i_serial_in_b({4{dly[2]}}), .o_recovered_char_clock(rclk), .o_char_strobe(strb), .o_char(chr),
        .o_data_valid(dv), .o_link_fault_n(lf), .o_tracking_training(trk), .o_ref_char_tick(tick),
        .o_config_reserved(resv));
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // cycles until the next char strobe, bounded
    task automatic next_char(output int gap);
        gap = 0;
        do
        begin
            @(posedge clk) #1;
            gap++;
        end
        while (strb[0] !== 1'b1 && gap < 40);
        chk("char strobe", 10'h1, 10'(strb[0]));
    endtask
    // wait for framed chars; gaps judged against the allowed stretch
    task automatic frame_run(input logic [1:0] p, input logic [1:0] m, input logic [3:0] s, input int most,
                             input int maxgap);
        int g, n;
        @(posedge clk);
        {fen, pat, mode, sel} <= {1'b1, p, m, s};
        // first gap starts mid-char, so it only syncs to the strobe
        next_char(g);
        for (n = 1; n <= most && chr[0] !== K28_NEG; n++)
        begin
            next_char(g);
            chk("char gap ok", 10'h1, 10'((g <= maxgap) && (g >= 10)));
        end
        chk("framed char", K28_NEG, chr[0]);
        for (n = 1; n < 4; n++) chk("channel char", chr[0], chr[n]);
    endtask
    // recovered clock rises and reference ticks over twenty bit times
    task automatic clock_run(input logic r, input int rises_exp);
        int   n, rises, ticks;
        logic prev;
        @(posedge clk);
        orate <= r;
        @(posedge clk) #1;
        prev  = rclk[0];
        rises = 0;
        ticks = 0;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk) #1;
            rises += int'(rclk[0] && !prev);
            ticks += int'(tick);
            prev  = rclk[0];
        end
        chk("clock rises", 10'(rises_exp), 10'(rises));
        chk("reference ticks", 10'h2, 10'(ticks));
        chk("tracking", 10'h0, 10'(trk));
    endtask
    task automatic t_disabled;
        int g;
        half <= 1'b1;
        spd  <= SEL_LOW;
        next_char(g);
        chk("reserved speed", 10'h1, 10'(resv));
        @(posedge clk);
        {half, spd} <= {1'b0, SEL_HIGH};
        repeat (5) next_char(g);
        chk("reserved clear", 10'h0, 10'(resv));
        chk("no stretch", 10'd10, 10'(g));
        chk("not framed", 10'h1, 10'(chr[0] !== K28_NEG));
    endtask
    task automatic t_fault;
        chk("link ok", 10'hF, 10'(lf & dv));
        @(posedge clk);
        {quiet, cen} <= {1'b1, 4'h7};
        repeat (64) @(posedge clk);
        #1 chk("fault raised", 10'h0, 10'(lf | dv));
        @(posedge clk);
        {quiet, cen} <= {1'b0, 4'hF};
        repeat (60) @(posedge clk);
        #1 chk("fault released", 10'hF, 10'(lf & dv));
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_disabled();
        frame_run(SEL_HIGH, 2'h0, 4'h0, 10, 12);
        frame_run(SEL_MID, 2'h1, 4'hF, 5, 10);
        frame_run(SEL_HIGH, 2'h2, 4'h0, 8, 10);
        clock_run(1'b1, 1);
        clock_run(1'b0, 2);
        t_fault();
        end_of_test();
    end
    initial
    begin
        #(100 * 3000);
        num_errors++;
        end_of_test();
    end
endmodule
